/* hdl/ext_bus_defs.svh */
// Purpose: constants for the external memory bus interface
// Assumes: 10 MHz clk, one phase per clock
// Notes:   the package holds the state type
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH
`define ONCHIP_LO     16'h2000
`define ONCHIP_HI     16'h5fff
`define CFG_DYNW_BIT  1
`define CFG_ALE_BIT   2
`define CFG_WRL_BIT   3
`define CFG_WRH_BIT   4
`define ADDR_W        16
`define PORT_W        8
`endif

/* hdl/ext_bus_pkg.sv */
// Purpose: shared types for the external memory bus interface
// Assumes: nothing
// Notes:   one-hot state codes
package ext_bus_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_END  = 4'b1000
  } bus_state_e;
endpackage : ext_bus_pkg

/* hdl/sync3.sv */
// Purpose: three-flop synchroniser for pin inputs
// Assumes: asynchronous inputs
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ns
module sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,     // clock
  input  wire logic sys_rst, // async reset
  input  wire logic din,     // raw pin
  output logic      dout     // filtered level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // first stage read only by the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule : sync3

/* hdl/ext_bus_if.sv */
// Purpose: external memory bus cycle generator
// Assumes: core issues one request at a time, holds it until ack
// Notes:   ad pins are open-drain port lines when idle
//          ready is synchronised, so a ready high left over from the last
//          cycle can end the next one early; leave a few idle cycles between
`timescale 1ns/1ns
`include "ext_bus_defs.svh"
module ext_bus_if
  import ext_bus_pkg::*;
#(
  parameter int AW = `ADDR_W,
  parameter int PW = `PORT_W
) (
  input  wire logic            clk,                    // 10 mhz clock
  input  wire logic            sys_rst,                // async reset, high
  input  wire logic [7:0]      chip_config_byte,       // configuration byte
  input  wire logic            req,                    // core access request
  input  wire logic            req_wr,                 // 1 write, 0 read
  input  wire logic            req_fetch,              // instruction fetch
  input  wire logic            req_word,               // 16-bit access
  input  wire logic [AW-1:0]   req_addr,               // byte address
  input  wire logic [15:0]     req_wdata,              // write data
  output logic                 ack,                    // done pulse
  output logic                 ack_ext,                // done went off chip
  output logic [15:0]          rdata,                  // read data
  input  wire logic            external_access_select, // on-chip memory pin
  input  wire logic            buswidth_pin,           // width select pin
  input  wire logic            ready_pin,              // ready pin
  input  wire logic [2*PW-1:0] ad_in,                  // bus pins in
  output logic      [2*PW-1:0] ad_out,                 // bus pins out
  output logic      [2*PW-1:0] ad_oe_n,                // low while driving
  output logic                 addr_strobe,            // latch or valid_n
  output logic                 read_n,                 // read strobe
  output logic                 write_low_byte_n,       // write / low write
  output logic                 write_high_byte_n,      // high write in either mode
  output logic                 fetch_type_indicator    // fetch indicator
);
  logic       ea_s;
  logic       bw_s;
  logic       rdy_s;
  bus_state_e st_q;
  logic       wr_q;
  logic       fetch_q;
  logic       w16_q;
  logic [AW-1:0] addr_q;
  logic [15:0]   wd_q;

  // pins from outside the clock domain
  sync3 #(.RST_VAL(1'b1)) u_ea  (.clk(clk), .sys_rst(sys_rst),
    .din(external_access_select), .dout(ea_s));
  sync3 #(.RST_VAL(1'b0)) u_bw  (.clk(clk), .sys_rst(sys_rst),
    .din(buswidth_pin), .dout(bw_s));
  sync3 #(.RST_VAL(1'b1)) u_rdy (.clk(clk), .sys_rst(sys_rst),
    .din(ready_pin), .dout(rdy_s));

  // address decode used for every request
  function automatic logic is_external(input logic [AW-1:0] a, input logic ea);
    is_external = !(ea && a >= `ONCHIP_LO && a <= `ONCHIP_HI);
  endfunction : is_external

  // pin level for the chosen address strobe form
  function automatic logic strobe_lvl(input logic latch_form, input logic active);
    strobe_lvl = latch_form ? active : !active;
  endfunction : strobe_lvl

  // read lane steering: an odd byte of an 8-bit cycle arrives on the high lane
  function automatic logic [15:0] rd_lane(input logic [15:0] bus, input logic odd,
                                          input logic wide);
    rd_lane = wide ? bus : {8'h00, (odd ? bus[15:8] : bus[7:0])};
  endfunction : rd_lane

  wire dynw   = chip_config_byte[`CFG_DYNW_BIT];
  wire ale_md = chip_config_byte[`CFG_ALE_BIT];
  wire wrl_md = chip_config_byte[`CFG_WRL_BIT];
  wire wrh_md = chip_config_byte[`CFG_WRH_BIT];
  wire ext_go = req && !ack && is_external(req_addr, ea_s);

  // cycle sequencer: address, data (stretched), release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: if (ext_go) st_q <= ST_ADDR;
        ST_ADDR: st_q <= ST_DATA;
        ST_DATA: if (rdy_s) st_q <= ST_END;
        ST_END:  st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // latch request attributes at the start of a cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q    <= 1'b0;
      fetch_q <= 1'b0;
      w16_q   <= 1'b0;
      addr_q  <= '0;
      wd_q    <= 16'h0000;
    end else if (st_q == ST_IDLE && ext_go) begin
      wr_q    <= req_wr;
      fetch_q <= req_fetch && !req_wr;
      addr_q  <= req_addr;
      wd_q    <= req_wdata;
      // width only when dynamic width enabled
      w16_q   <= dynw && bw_s && req_word;
    end
  end

  // strobes, all registered; ready only matters in data phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_strobe          <= 1'b1;
      read_n               <= 1'b1;
      write_low_byte_n     <= 1'b1;
      write_high_byte_n    <= 1'b1;
      fetch_type_indicator <= 1'b0;
    end else begin
      addr_strobe          <= strobe_lvl(ale_md, 1'b0);
      read_n               <= 1'b1;
      write_low_byte_n     <= 1'b1;
      write_high_byte_n    <= 1'b1;
      fetch_type_indicator <= 1'b0;
      if (st_q == ST_IDLE && ext_go) begin
        addr_strobe          <= strobe_lvl(ale_md, 1'b1);
        fetch_type_indicator <= req_fetch && !req_wr;
      end else if (st_q == ST_ADDR || (st_q == ST_DATA && !rdy_s)) begin
        addr_strobe          <= 1'b0;                 // pulse over, level held
        fetch_type_indicator <= fetch_q;
        read_n               <= wr_q;
        if (wr_q) begin
          write_low_byte_n  <= wrl_md ? addr_q[0] : 1'b0;
          write_high_byte_n <= wrh_md ? !(addr_q[0] || w16_q)
                                      : !(addr_q[0] || w16_q);
          if (wrl_md && w16_q) write_low_byte_n <= 1'b0;
        end
      end
    end
  end

  // bus pins: address, then write data; released otherwise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ad_out  <= '0;
      ad_oe_n <= '1;
    end else if (st_q == ST_IDLE && ext_go) begin
      ad_out  <= (2*PW)'(req_addr);
      ad_oe_n <= '0;
    end else if ((st_q == ST_ADDR || st_q == ST_DATA) && wr_q) begin
      ad_out  <= (addr_q[0] && !w16_q) ? {wd_q[7:0], wd_q[7:0]} : wd_q;
      ad_oe_n <= '0;
    end else begin
      ad_oe_n <= '1;
    end
  end

  // completion; ready is not looked at outside ST_DATA
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack     <= 1'b0;
      ack_ext <= 1'b0;
      rdata   <= 16'h0000;
    end else begin
      ack     <= 1'b0;
      ack_ext <= 1'b0;
      if (st_q == ST_DATA && rdy_s) begin
        ack     <= 1'b1;
        ack_ext <= 1'b1;
        if (!wr_q) begin
          rdata <= rd_lane(ad_in, addr_q[0], w16_q);
        end
      end else if (req && !ack && st_q == ST_IDLE && !is_external(req_addr, ea_s)) begin
        ack <= 1'b1; // on chip: no strobes at all
      end
    end
  end

  // cycles since the start of an external cycle, only read by the checks
  logic [3:0] len_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      len_q <= 4'h0;
    end else if (st_q == ST_IDLE) begin
      len_q <= 4'h0;
    end else if (len_q != 4'hf) begin
      len_q <= len_q + 4'h1;
    end
  end

  // checks
  sequence s_start;
    st_q == ST_IDLE && ext_go;
  endsequence
  sequence s_addr_ph;
    st_q == ST_ADDR;
  endsequence
  sequence s_data_ph;
    st_q == ST_DATA;
  endsequence
  property p_rd_only_ext;
    @(posedge clk) disable iff (sys_rst) !read_n |-> $past(st_q) != ST_IDLE;
  endproperty
  a_rd_only_ext: assert property (p_rd_only_ext) else $error("read strobe outside cycle");
  property p_no_rd_on_wr;
    @(posedge clk) disable iff (sys_rst) !read_n |-> write_low_byte_n && write_high_byte_n;
  endproperty
  a_no_rd_on_wr: assert property (p_no_rd_on_wr) else $error("read and write together");
  property p_wrh_only_wr;
    @(posedge clk) disable iff (sys_rst) !write_high_byte_n |-> wr_q;
  endproperty
  a_wrh_only_wr: assert property (p_wrh_only_wr) else $error("high strobe on read");
  property p_addr_first;
    @(posedge clk) disable iff (sys_rst) s_start |=> s_addr_ph ##1 s_data_ph;
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("phase order wrong");
  property p_stretch;
    @(posedge clk) disable iff (sys_rst) st_q == ST_DATA && !rdy_s |=> st_q == ST_DATA;
  endproperty
  a_stretch: assert property (p_stretch) else $error("cycle not stretched");
  property p_ready_ign;
    @(posedge clk) disable iff (sys_rst) st_q == ST_IDLE && !ext_go |=> !ack_ext;
  endproperty
  a_ready_ign: assert property (p_ready_ign) else $error("ready acted when idle");
  property p_w8;
    @(posedge clk) disable iff (sys_rst) s_start ##0 !dynw |=> !w16_q;
  endproperty
  a_w8: assert property (p_w8) else $error("16-bit with dynamic width off");
  property p_fetch_type_indicator_wr;
    @(posedge clk) disable iff (sys_rst) fetch_type_indicator |-> !wr_q || st_q == ST_ADDR;
  endproperty
  a_fetch_type_indicator_wr: assert property (p_fetch_type_indicator_wr) else $error("fetch flag on write");
  property p_onchip;
    @(posedge clk) disable iff (sys_rst)
      req && !ack && st_q == ST_IDLE && ea_s && req_addr >= `ONCHIP_LO
      && req_addr <= `ONCHIP_HI |=> st_q == ST_IDLE;
  endproperty
  a_onchip: assert property (p_onchip) else $error("on-chip access went out");

  // strobe form checks; the form in force is the one seen at the launching edge
  property p_adv_end;
    @(posedge clk) disable iff (sys_rst) ack_ext |-> $past(ale_md) || addr_strobe;
  endproperty
  a_adv_end: assert property (p_adv_end) else $error("valid level not returned");
  property p_ale_pulse;
    @(posedge clk) disable iff (sys_rst) $past(ale_md) && addr_strobe |=> !addr_strobe;
  endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch pulse too long");
  property p_as_ext;
    @(posedge clk) disable iff (sys_rst)
      strobe_lvl($past(ale_md), addr_strobe) |-> st_q == ST_ADDR || st_q == ST_DATA;
  endproperty
  a_as_ext: assert property (p_as_ext) else $error("address strobe outside cycle");

  // write strobe checks
  property p_wrl_wr;
    @(posedge clk) disable iff (sys_rst) !write_low_byte_n |-> wr_q && st_q == ST_DATA;
  endproperty
  a_wrl_wr: assert property (p_wrl_wr) else $error("low write strobe off a write");
  property p_wrl_even;
    @(posedge clk) disable iff (sys_rst)
      $past(wrl_md) && !write_low_byte_n |-> !addr_q[0] || w16_q;
  endproperty
  a_wrl_even: assert property (p_wrl_even) else $error("write-low on odd byte");
  property p_wr_every;
    @(posedge clk) disable iff (sys_rst)
      !$past(wrl_md) && wr_q && st_q == ST_DATA |-> !write_low_byte_n;
  endproperty
  a_wr_every: assert property (p_wr_every) else $error("plain write strobe missing");
  property p_wrh_odd;
    @(posedge clk) disable iff (sys_rst) !write_high_byte_n |-> addr_q[0] || w16_q;
  endproperty
  a_wrh_odd: assert property (p_wrh_odd) else $error("high strobe on even byte");
  property p_wrh_set;
    @(posedge clk) disable iff (sys_rst)
      wr_q && st_q == ST_DATA && (addr_q[0] || w16_q) |-> !write_high_byte_n;
  endproperty
  a_wrh_set: assert property (p_wrh_set) else $error("high strobe missing");
  property p_wrh_data;
    @(posedge clk) disable iff (sys_rst) !write_high_byte_n |-> st_q == ST_DATA;
  endproperty
  a_wrh_data: assert property (p_wrh_data) else $error("high strobe outside data");

  // data phase checks
  property p_rd_whole;
    @(posedge clk) disable iff (sys_rst) !wr_q && st_q == ST_DATA |-> !read_n;
  endproperty
  a_rd_whole: assert property (p_rd_whole) else $error("read strobe dropped early");
  property p_fetch_whole;
    @(posedge clk) disable iff (sys_rst) st_q == ST_DATA |-> fetch_type_indicator == fetch_q;
  endproperty
  a_fetch_whole: assert property (p_fetch_whole) else $error("fetch flag not held");
  property p_fetch_ext;
    @(posedge clk) disable iff (sys_rst)
      fetch_type_indicator |-> st_q == ST_ADDR || st_q == ST_DATA;
  endproperty
  a_fetch_ext: assert property (p_fetch_ext) else $error("fetch flag outside cycle");
  property p_ready_data;
    @(posedge clk) disable iff (sys_rst) st_q != ST_DATA |=> !ack_ext;
  endproperty
  a_ready_data: assert property (p_ready_data) else $error("ended outside data");
  property p_w16;
    @(posedge clk) disable iff (sys_rst) s_start ##0 (dynw && bw_s && req_word) |=> w16_q;
  endproperty
  a_w16: assert property (p_w16) else $error("16-bit cycle not taken");

  // bus pin and release checks
  property p_oe_idle;
    @(posedge clk) disable iff (sys_rst) st_q == ST_IDLE |-> &ad_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("bus driven while idle");
  property p_addr_drive;
    @(posedge clk) disable iff (sys_rst)
      st_q == ST_ADDR |-> ad_oe_n == '0 && ad_out == (2*PW)'(addr_q);
  endproperty
  a_addr_drive: assert property (p_addr_drive) else $error("address not driven");
  property p_release;
    @(posedge clk) disable iff (sys_rst)
      ack_ext |-> read_n && write_low_byte_n && write_high_byte_n;
  endproperty
  a_release: assert property (p_release) else $error("strobes not released");
  property p_len;
    @(posedge clk) disable iff (sys_rst) ack_ext |-> len_q >= 4'h2;
  endproperty
  a_len: assert property (p_len) else $error("cycle shorter than two phases");
endmodule : ext_bus_if

/* test/ext_mem_model.sv */
// Purpose: external memory partner for the bus interface bench
// Assumes: latch_form matches the strobe form the device is set to
// Notes:   released ad lines float high through the pullups
`timescale 1ns/1ns
module ext_mem_model (
  input  wire logic        clk,         // bus clock
  input  wire logic        latch_form,  // 1 latch pulse, 0 valid level
  input  wire logic [3:0]  waits,       // wait cycles before ready
  input  wire logic [15:0] ad_out,      // device drive
  input  wire logic [15:0] ad_oe_n,     // device enables, low drives
  input  wire logic        addr_strobe, // address strobe
  input  wire logic        read_n,      // read strobe
  input  wire logic        wr_lo_n,     // low write strobe
  input  wire logic        wr_hi_n,     // high write strobe
  output logic [15:0]      ad_in,       // resolved wire
  output logic             ready_pin,   // ready to device
  output logic [15:0]      wdat_q       // last written data
);
  logic [15:0] addr_q;
  logic [3:0]  cnt_q;
  wire         data_ph = !read_n || !wr_lo_n || !wr_hi_n;
  // pullups win where nobody drives; read data is the inverted address
  assign ad_in = (~ad_oe_n & ad_out) | (ad_oe_n & (read_n ? 16'hffff : ~addr_q));
  // take the address only before the data phase opens
  always_ff @(posedge clk) begin
    if ((latch_form ? addr_strobe : !addr_strobe) && !data_ph) addr_q <= ad_out;
  end
  // ready stays low when idle too, but a stale high can still sit in the device's ready synchroniser
  always_ff @(posedge clk) begin
    cnt_q <= data_ph ? cnt_q + 4'h1 : 4'h0;
    ready_pin <= data_ph && cnt_q >= waits;
    if (!wr_lo_n || !wr_hi_n) wdat_q <= ad_out;
  end
endmodule : ext_mem_model

/* test/external_memory_bus_interface_tb.sv */
// Purpose: self-checking bench for the external bus cycle generator
// Assumes: 10 mhz clock, strobes watched at every edge
// Notes:   the even-byte lane of an 8-bit read is compared
`timescale 1ns/1ns
module external_memory_bus_interface_tb;
  logic clk = 1'b0, sys_rst = 1'b1, req = 1'b0, req_wr = 1'b0, req_fetch = 1'b0;
  logic req_word = 1'b0, external_access_select = 1'b0, buswidth_pin = 1'b0;
  logic [7:0]  chip_config_byte = 8'h00;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, rdata, ad_in, ad_out, ad_oe_n, wdat;
  logic [3:0]  waits = 4'h0;
  logic ack, ack_ext, ready_pin, addr_strobe, read_n, wl_n, wh_n, fi, xs;
  logic s_rd, s_wl, s_wh, s_as, s_f;
  int err_total = 0, check_count = 0, lat, l0;
  ext_bus_if ext_bus_if_i (.clk, .sys_rst, .chip_config_byte, .req, .req_wr, .req_fetch,
    .req_word, .req_addr, .req_wdata, .ack, .ack_ext, .rdata, .external_access_select,
    .buswidth_pin, .ready_pin, .ad_in, .ad_out, .ad_oe_n, .addr_strobe, .read_n,
    .write_low_byte_n(wl_n), .write_high_byte_n(wh_n), .fetch_type_indicator(fi));
  ext_mem_model ext_mem_model_i (.clk, .latch_form(chip_config_byte[2]), .waits, .ad_out,
    .ad_oe_n, .addr_strobe, .read_n, .wr_lo_n(wl_n), .wr_hi_n(wh_n), .ad_in, .ready_pin,
    .wdat_q(wdat));
  always #50 clk = ~clk;
  // sticky record of every strobe seen during one access
  always @(posedge clk) begin
    s_rd |= !read_n; s_wl |= !wl_n; s_wh |= !wh_n; s_f |= fi;
    s_as |= chip_config_byte[2] ? addr_strobe : !addr_strobe;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (exp !== got) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // pins pass a three-flop sync, so give them time to settle
  task automatic setup(input logic [7:0] c, input logic e, b, input logic [3:0] w);
    @(posedge clk);
    chip_config_byte <= c; external_access_select <= e; buswidth_pin <= b; waits <= w;
    repeat (6) @(posedge clk);
  endtask : setup
  // lead-in drains the synchronised ready; req drops at the edge ack is seen
  task automatic acc(input logic wr, f, w, input logic [15:0] a, d);
    repeat (5) @(posedge clk);
    req <= 1'b1; req_wr <= wr; req_fetch <= f; req_word <= w; req_addr <= a; req_wdata <= d;
    #1 {s_rd, s_wl, s_wh, s_as, s_f} = 5'h00;
    for (lat = 0; lat < 60; lat++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    xs = ack_ext;
    req <= 1'b0;
    if (lat == 60) begin
      err_total++;
      tally_and_finish();
    end
  endtask : acc
  task automatic t_map();
    logic [15:0] tab [4] = '{16'h1ffd, 16'h2000, 16'h5fff, 16'h6000};
    setup(8'h00, 1'b1, 1'b0, 4'h0);
    foreach (tab[i]) begin
      acc(1'b0, 1'b1, 1'b0, tab[i], 16'h0000);
      chk("ack_ext", 16'(tab[i] < 16'h2000 || tab[i] > 16'h5fff), 16'(xs));
      if (xs !== 1'b1) chk("onchip strobes", 16'h0, {s_rd, s_as, s_f});
      if (xs !== 1'b1) chk("onchip fast", 16'h1, 16'(lat < 4));
    end
    $display("test map done");
  endtask : t_map
  task automatic t_read();
    setup(8'h02, 1'b0, 1'b1, 4'h0);
    acc(1'b0, 1'b1, 1'b1, 16'h2000, 16'h0000);
    l0 = lat;
    chk("rdata", ~16'h2000, rdata);
    chk("read strobes", 16'h13, {s_rd, s_wl, s_wh, s_as, s_f});
    chk("released", 16'h3, {addr_strobe, read_n});
    acc(1'b0, 1'b0, 1'b1, 16'h6000, 16'h0000);
    chk("data fetch", 16'h0, 16'(s_f));
    setup(8'h02, 1'b0, 1'b1, 4'h6);
    acc(1'b0, 1'b0, 1'b1, 16'h6000, 16'h0000);
    chk("stretch", 16'h1, 16'(lat - l0 >= 6));
    setup(8'h00, 1'b0, 1'b1, 4'h0);
    acc(1'b0, 1'b0, 1'b1, 16'h6000, 16'h0000);
    chk("narrow", 16'h00ff, rdata);
    $display("test read done");
  endtask : t_read
  task automatic t_write();
    logic [7:0] cf [3] = '{8'h08, 8'h00, 8'h14};
    foreach (cf[i]) begin
      setup(cf[i], 1'b0, 1'b0, 4'h0);
      for (int o = 0; o < 2; o++) begin
        acc(1'b1, 1'b0, 1'b0, 16'h6000 + 16'(o), 16'h5aa5);
        chk("wr low", 16'(cf[i][3] ? o == 0 : 1), 16'(s_wl));
        chk("wr high", 16'(o), 16'(s_wh));
        chk("no read", 16'h0, 16'(s_rd));
      end
    end
    setup(8'h0a, 1'b0, 1'b1, 4'h0);
    acc(1'b1, 1'b0, 1'b1, 16'h6000, 16'h1234);
    chk("word write", 16'h1234, wdat);
    chk("word strobes", 16'h3, {s_wl, s_wh});
    $display("test write done");
  endtask : t_write
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_map();
    t_read();
    t_write();
    tally_and_finish();
  end
endmodule : external_memory_bus_interface_tb
